// >>> logic/stm_pkg.sv
package stm_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned CLK_NS         = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RAMP_TICK_US   = 1000;
  localparam int unsigned RAMP_TICK_CYC  = RAMP_TICK_US * 1000 / CLK_NS;
  localparam int unsigned PAUSE_UNIT_NS  = 32000;
  // least time per unit, so round up
  localparam int unsigned PAUSE_UNIT_CYC =
    (PAUSE_UNIT_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // widths
  localparam int unsigned AP_W    = 8;
  localparam int unsigned DW      = 32;
  localparam int unsigned POS_W   = 32;
  localparam int unsigned VEL_W   = 23;
  localparam int unsigned ACC_W   = 23;
  localparam int unsigned V1_W    = 20;
  localparam int unsigned VS_W    = 18;
  localparam int unsigned PAUSE_W = 16;
  localparam int unsigned CUR_W   = 8;

  // ramp step = rate >> STEP_SHIFT per tick; braking look-ahead
  localparam int unsigned STEP_SHIFT  = 10;
  localparam int unsigned BRAKE_SHIFT = 4;

  // ==========================================================
  // axis parameter numbers
  localparam logic [AP_W-1:0] AP_STANDBY  = 8'h07;
  localparam logic [AP_W-1:0] AP_REACHED  = 8'h08;
  localparam logic [AP_W-1:0] AP_HOME     = 8'h09;
  localparam logic [AP_W-1:0] AP_RIGHT    = 8'h0a;
  localparam logic [AP_W-1:0] AP_LEFT     = 8'h0b;
  localparam logic [AP_W-1:0] AP_R_IGN    = 8'h0c;
  localparam logic [AP_W-1:0] AP_L_IGN    = 8'h0d;
  localparam logic [AP_W-1:0] AP_XCHG     = 8'h0e;
  localparam logic [AP_W-1:0] AP_A1       = 8'h0f;
  localparam logic [AP_W-1:0] AP_V1       = 8'h10;
  localparam logic [AP_W-1:0] AP_DMAX     = 8'h11;
  localparam logic [AP_W-1:0] AP_D1       = 8'h12;
  localparam logic [AP_W-1:0] AP_LAUNCH   = 8'h13;
  localparam logic [AP_W-1:0] AP_HALT     = 8'h14;
  localparam logic [AP_W-1:0] AP_PAUSE    = 8'h15;
  localparam logic [AP_W-1:0] AP_THR      = 8'h16;
  localparam logic [AP_W-1:0] AP_ADMIN    = 8'h17;
  localparam logic [AP_W-1:0] AP_R_INV    = 8'h18;
  localparam logic [AP_W-1:0] AP_L_INV    = 8'h19;
  localparam logic [AP_W-1:0] AP_SOFT     = 8'h1a;
  localparam logic [AP_W-1:0] AP_FCHOP    = 8'h1b;
  localparam logic [AP_W-1:0] AP_FFULL    = 8'h1c;
  localparam logic [AP_W-1:0] AP_MEAS     = 8'h1d;

  // ==========================================================
  // reset values
  localparam logic [CUR_W-1:0]   RST_STANDBY = 8'h00;
  localparam logic               RST_BIT     = 1'h0;
  localparam logic [ACC_W-1:0]   RST_ACC     = 23'h0;
  localparam logic [V1_W-1:0]    RST_V1      = 20'h0;
  localparam logic [VS_W-1:0]    RST_VS      = 18'h0;
  localparam logic [PAUSE_W-1:0] RST_PAUSE   = 16'h0;

  // ==========================================================
  // types
  typedef struct packed {
    logic home;
    logic right;
    logic left;
  } stm_sw_t;

  typedef struct packed {
    logic chop_alt;
    logic fullstep;
    logic lac_off;
    logic adapt;
  } stm_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_BRAKE = 4'b0100,
    ST_WAIT  = 4'b1000
  } stm_state_t;

  // ==========================================================
  // parameter number decode
  function automatic logic ap_known(input logic [AP_W-1:0] n);
    return (n >= AP_STANDBY) && (n <= AP_MEAS);
  endfunction : ap_known

  function automatic logic ap_ro(input logic [AP_W-1:0] n);
    return n inside {AP_REACHED, AP_HOME, AP_RIGHT, AP_LEFT, AP_MEAS};
  endfunction : ap_ro

endpackage : stm_pkg

// >>> logic/stm_vstep.sv
`timescale 1ns/100ps
module stm_vstep
  import stm_pkg::*;
#(
  parameter int unsigned W = VEL_W
) (
  input  wire logic [W-1:0] v_i,    // present speed
  input  wire logic [W-1:0] goal_i, // speed to approach
  input  wire logic [W-1:0] rate_i, // accel or decel setting
  output logic      [W-1:0] v_o     // speed after one tick
);

  if (W <= STEP_SHIFT) begin : g_chk
    $error("stm_vstep: W too small");
  end

  logic [W-1:0] step;
  logic [W:0]   up;

  // never overshoots the goal; a tiny rate still moves one unit
  always_comb begin
    step = rate_i >> STEP_SHIFT;
    if (step == '0) begin
      step = W'(1);
    end
    up = {1'b0, v_i} + {1'b0, step};
    if (v_i < goal_i) begin
      v_o = (up > {1'b0, goal_i}) ? goal_i : up[W-1:0];
    end else if (v_i > goal_i) begin
      v_o = ((v_i - goal_i) < step) ? goal_i : v_i - step;
    end else begin
      v_o = v_i;
    end
  end

endmodule : stm_vstep

// >>> logic/stm_axis_ctrl.sv
// Contract
// - when stopped, motor current is the 8-bit standby code, 255 full scale.
// - a set ignore bit removes that limit switch's stop action.
// - a set invert bit flips that limit switch's sensed level.
// - with gentle halt on, a limit stop ramps down instead of halting.
// - ramp heads for first-phase speed; zero skips it, max rates only.
// - max decel applies from top speed down to first-phase speed.
// - first-phase decel applies between first-phase and halt speed.
// - after reaching zero, wait the pause count in 32 us units.
// - above the threshold, load-adaptive current control is turned off.
// - fast chopper bit and speed above threshold select other chopper.
// - fast fullstep bit and speed above threshold select full step.
// - load-adaptive commutation only above its minimum speed.
// - measured driver speed is readable, read only.
`timescale 1ns/100ps
module stm_axis_ctrl
  import stm_pkg::*;
#(
  parameter int unsigned TICK_CYC  = RAMP_TICK_CYC,
  parameter int unsigned UNIT_CYC  = PAUSE_UNIT_CYC
) (
  input  wire logic              ref_clk_i,    // module clock
  input  wire logic              nrst_i,       // async reset, low
  input  wire logic [AP_W-1:0]   ap_num_i,     // parameter number
  input  wire logic [DW-1:0]     ap_wdata_i,   // set value
  input  wire logic              ap_wr_i,      // set strobe
  input  wire logic              ap_rd_i,      // get strobe
  output logic      [DW-1:0]     ap_rdata_o,   // get value
  output logic                   ap_ack_o,     // access done
  output logic                   ap_err_o,     // bad number/RO
  input  wire logic [POS_W-1:0]  target_pos_i, // target position
  input  wire logic [POS_W-1:0]  actual_pos_i, // actual position
  input  wire logic [VEL_W-1:0]  vmax_i,       // top speed
  input  wire logic [ACC_W-1:0]  amax_i,       // max accel
  input  wire logic [CUR_W-1:0]  run_cur_i,    // run current
  input  wire logic [VEL_W-1:0]  meas_speed_i, // driver speed
  input  wire stm_sw_t           sw_i,         // raw switches
  output logic      [VEL_W-1:0]  vel_o,        // commanded speed
  output logic                   dir_o,        // 1 = right
  output logic                   running_o,    // ramp active
  output logic      [CUR_W-1:0]  cur_o,        // current scale
  output stm_mode_t              mode_o,       // driver modes
  output logic                   stop_right_o, // right blocked
  output logic                   stop_left_o   // left blocked
);

  if (TICK_CYC < 1 || UNIT_CYC < 1) begin : g_chk
    $error("stm_axis_ctrl: cycle counts must be at least 1");
  end

  localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);
  localparam int unsigned UNIT_W = $clog2(UNIT_CYC + 1);

  // ==========================================================
  // settings
  logic [CUR_W-1:0]   standby_r;
  logic               r_ign_r;
  logic               l_ign_r;
  logic               xchg_r;
  logic [ACC_W-1:0]   a1_r;
  logic [V1_W-1:0]    v1_r;
  logic [ACC_W-1:0]   dmax_r;
  logic [ACC_W-1:0]   d1_r;
  logic [VS_W-1:0]    launch_r;
  logic [VS_W-1:0]    halt_r;
  logic [PAUSE_W-1:0] pause_r;
  logic [VEL_W-1:0]   thr_r;
  logic [VEL_W-1:0]   admin_r;
  logic               r_inv_r;
  logic               l_inv_r;
  logic               soft_r;
  logic               fchop_r;
  logic               ffull_r;

  logic wr_ok;
  assign wr_ok = ap_wr_i && ap_known(ap_num_i) && !ap_ro(ap_num_i);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      standby_r <= RST_STANDBY;
      r_ign_r   <= RST_BIT;
      l_ign_r   <= RST_BIT;
      xchg_r    <= RST_BIT;
      a1_r      <= RST_ACC;
      v1_r      <= RST_V1;
      dmax_r    <= RST_ACC;
      d1_r      <= RST_ACC;
      launch_r  <= RST_VS;
      halt_r    <= RST_VS;
      pause_r   <= RST_PAUSE;
      thr_r     <= RST_ACC;
      admin_r   <= RST_ACC;
      r_inv_r   <= RST_BIT;
      l_inv_r   <= RST_BIT;
      soft_r    <= RST_BIT;
      fchop_r   <= RST_BIT;
      ffull_r   <= RST_BIT;
    end else if (wr_ok) begin
      case (ap_num_i)
        AP_STANDBY: standby_r <= ap_wdata_i[CUR_W-1:0];
        AP_R_IGN:   r_ign_r   <= ap_wdata_i[0];
        AP_L_IGN:   l_ign_r   <= ap_wdata_i[0];
        AP_XCHG:    xchg_r    <= ap_wdata_i[0];
        AP_A1:      a1_r      <= ap_wdata_i[ACC_W-1:0];
        AP_V1:      v1_r      <= ap_wdata_i[V1_W-1:0];
        AP_DMAX:    dmax_r    <= ap_wdata_i[ACC_W-1:0];
        AP_D1:      d1_r      <= ap_wdata_i[ACC_W-1:0];
        AP_LAUNCH:  launch_r  <= ap_wdata_i[VS_W-1:0];
        AP_HALT:    halt_r    <= ap_wdata_i[VS_W-1:0];
        AP_PAUSE:   pause_r   <= ap_wdata_i[PAUSE_W-1:0];
        AP_THR:     thr_r     <= ap_wdata_i[VEL_W-1:0];
        AP_ADMIN:   admin_r   <= ap_wdata_i[VEL_W-1:0];
        AP_R_INV:   r_inv_r   <= ap_wdata_i[0];
        AP_L_INV:   l_inv_r   <= ap_wdata_i[0];
        AP_SOFT:    soft_r    <= ap_wdata_i[0];
        AP_FCHOP:   fchop_r   <= ap_wdata_i[0];
        AP_FFULL:   ffull_r   <= ap_wdata_i[0];
        default:    ;
      endcase
    end
  end

  // ==========================================================
  // switch conditioning and position status
  stm_sw_t          sw_x;
  stm_sw_t          sw_r;
  logic             reached_r;
  logic [VEL_W-1:0] meas_r;
  logic             stop_r_c;
  logic             stop_l_c;

  always_comb begin
    sw_x = sw_i;
    if (xchg_r) begin
      sw_x.right = sw_i.left;
      sw_x.left  = sw_i.right;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_r      <= '0;
      reached_r <= RST_BIT;
      meas_r    <= '0;
    end else begin
      sw_r.home  <= sw_x.home;
      sw_r.right <= sw_x.right ^ r_inv_r;
      sw_r.left  <= sw_x.left ^ l_inv_r;
      reached_r  <= (target_pos_i == actual_pos_i);
      meas_r     <= meas_speed_i;
    end
  end

  assign stop_r_c = sw_r.right && !r_ign_r;
  assign stop_l_c = sw_r.left && !l_ign_r;

  // ==========================================================
  // ramp generator
  stm_state_t        state_r;
  logic [VEL_W-1:0]  v_r;
  logic              dir_r;
  logic [TICK_W-1:0] tick_r;
  logic              tick;
  logic [UNIT_W-1:0] unit_r;
  logic [PAUSE_W-1:0] units_r;
  logic [VEL_W-1:0]  goal;
  logic [VEL_W-1:0]  rate;
  logic [VEL_W-1:0]  v_step;
  logic              v1_on;
  logic              need_dir;
  logic              blocked;
  logic              hit;
  logic              near;
  logic [POS_W:0]    diff;
  logic [POS_W:0]    remain;

  assign tick     = (tick_r == TICK_W'(TICK_CYC - 1));
  assign v1_on    = (v1_r != '0);
  assign need_dir = $signed(target_pos_i) > $signed(actual_pos_i);
  assign blocked  = need_dir ? stop_r_c : stop_l_c;
  assign hit      = dir_r ? stop_r_c : stop_l_c;
  assign diff     = {target_pos_i[POS_W-1], target_pos_i}
                  - {actual_pos_i[POS_W-1], actual_pos_i};
  assign remain   = diff[POS_W] ? (POS_W + 1)'(-diff) : diff;
  // crude look-ahead: no divider, so braking starts early enough
  // only for moderate decel settings
  assign near     = remain <= (POS_W + 1)'(v_r >> BRAKE_SHIFT);

  always_comb begin
    goal = vmax_i;
    rate = amax_i;
    if (state_r == ST_RUN) begin
      if (v1_on && v_r < VEL_W'(v1_r)) begin
        rate = a1_r;
      end
    end else begin
      goal = VEL_W'(halt_r);
      if (v1_on && v_r <= VEL_W'(v1_r)) begin
        rate = d1_r;
      end else begin
        rate = dmax_r;
      end
    end
  end

  stm_vstep #(
    .W (VEL_W)
  ) u_vstep (
    .v_i    (v_r),
    .goal_i (goal),
    .rate_i (rate),
    .v_o    (v_step)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_r <= '0;
    end else if (tick) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + TICK_W'(1);
    end
  end

  // pause counted only while waiting, restarts on each entry
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      unit_r  <= '0;
      units_r <= '0;
    end else if (state_r != ST_WAIT) begin
      unit_r  <= '0;
      units_r <= '0;
    end else if (unit_r == UNIT_W'(UNIT_CYC - 1)) begin
      unit_r  <= '0;
      units_r <= units_r + PAUSE_W'(1);
    end else begin
      unit_r <= unit_r + UNIT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_IDLE;
      v_r     <= '0;
      dir_r   <= RST_BIT;
    end else begin
      case (state_r)
        ST_IDLE: begin
          v_r <= '0;
          // flag lags a cycle: live compare blocks a start out of reset
          if (!reached_r && (target_pos_i != actual_pos_i) && !blocked) begin
            state_r <= ST_RUN;
            dir_r   <= need_dir;
            v_r     <= VEL_W'(launch_r);
          end
        end
        ST_RUN: begin
          if (hit && soft_r) begin
            state_r <= ST_BRAKE;
          end else if (hit) begin
            state_r <= ST_WAIT;
            v_r     <= '0;
          end else if (reached_r || near) begin
            state_r <= ST_BRAKE;
          end else if (tick) begin
            v_r <= v_step;
          end
        end
        ST_BRAKE: begin
          if ((hit && !soft_r) || reached_r) begin
            state_r <= ST_WAIT;
            v_r     <= '0;
          end else if (tick) begin
            if (v_step <= VEL_W'(halt_r)) begin
              state_r <= ST_WAIT;
              v_r     <= '0;
            end else begin
              v_r <= v_step;
            end
          end
        end
        ST_WAIT: begin
          v_r <= '0;
          if (units_r >= pause_r) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          v_r     <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  logic moving;
  assign moving = (state_r == ST_RUN) || (state_r == ST_BRAKE);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_o        <= RST_STANDBY;
      running_o    <= RST_BIT;
      stop_right_o <= RST_BIT;
      stop_left_o  <= RST_BIT;
    end else begin
      cur_o        <= moving ? run_cur_i : standby_r;
      running_o    <= moving;
      stop_right_o <= stop_r_c;
      stop_left_o  <= stop_l_c;
    end
  end

  assign vel_o = v_r;
  assign dir_o = dir_r;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_o <= '0;
    end else begin
      mode_o.lac_off  <= meas_r > thr_r;
      mode_o.chop_alt <= fchop_r && (meas_r > thr_r);
      mode_o.fullstep <= ffull_r && (meas_r > thr_r);
      mode_o.adapt    <= meas_r > admin_r;
    end
  end

  // ==========================================================
  // parameter read-back
  logic [DW-1:0] rd_mux;

  always_comb begin
    case (ap_num_i)
      AP_STANDBY: rd_mux = DW'(standby_r);
      AP_REACHED: rd_mux = DW'(reached_r);
      AP_HOME:    rd_mux = DW'(sw_r.home);
      AP_RIGHT:   rd_mux = DW'(sw_r.right);
      AP_LEFT:    rd_mux = DW'(sw_r.left);
      AP_R_IGN:   rd_mux = DW'(r_ign_r);
      AP_L_IGN:   rd_mux = DW'(l_ign_r);
      AP_XCHG:    rd_mux = DW'(xchg_r);
      AP_A1:      rd_mux = DW'(a1_r);
      AP_V1:      rd_mux = DW'(v1_r);
      AP_DMAX:    rd_mux = DW'(dmax_r);
      AP_D1:      rd_mux = DW'(d1_r);
      AP_LAUNCH:  rd_mux = DW'(launch_r);
      AP_HALT:    rd_mux = DW'(halt_r);
      AP_PAUSE:   rd_mux = DW'(pause_r);
      AP_THR:     rd_mux = DW'(thr_r);
      AP_ADMIN:   rd_mux = DW'(admin_r);
      AP_R_INV:   rd_mux = DW'(r_inv_r);
      AP_L_INV:   rd_mux = DW'(l_inv_r);
      AP_SOFT:    rd_mux = DW'(soft_r);
      AP_FCHOP:   rd_mux = DW'(fchop_r);
      AP_FFULL:   rd_mux = DW'(ffull_r);
      AP_MEAS:    rd_mux = DW'(meas_r);
      default:    rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ap_rdata_o <= '0;
      ap_ack_o   <= RST_BIT;
      ap_err_o   <= RST_BIT;
    end else begin
      ap_ack_o <= ap_wr_i || ap_rd_i;
      ap_err_o <= (ap_wr_i || ap_rd_i) && (!ap_known(ap_num_i)
                  || (ap_wr_i && ap_ro(ap_num_i)));
      if (ap_rd_i) begin
        ap_rdata_o <= rd_mux;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  localparam int unsigned CYC_W = PAUSE_W + UNIT_W + 1;

  logic [CYC_W-1:0] wait_cyc_r;

  // cycles spent waiting, kept apart from the unit counter
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_cyc_r <= '0;
    end else if (state_r != ST_WAIT) begin
      wait_cyc_r <= '0;
    end else begin
      wait_cyc_r <= wait_cyc_r + CYC_W'(1);
    end
  end

  property p_standby;
    !moving |=> cur_o == $past(standby_r);
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby current not applied");

  property p_ignore;
    r_ign_r |=> !stop_right_o;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignored right switch still stops");

  property p_ignore_l;
    l_ign_r |=> !stop_left_o;
  endproperty
  a_ignore_l: assert property (p_ignore_l)
    else $error("ignored left switch still stops");

  property p_invert;
    !xchg_r |=> sw_r.right == ($past(sw_i.right) ^ $past(r_inv_r));
  endproperty
  a_invert: assert property (p_invert)
    else $error("right switch polarity wrong");

  property p_swap;
    xchg_r |=> sw_r.left == ($past(sw_i.right) ^ $past(l_inv_r));
  endproperty
  a_swap: assert property (p_swap)
    else $error("switch exchange wrong");

  property p_soft;
    (state_r == ST_RUN) && hit && soft_r |=> state_r == ST_BRAKE;
  endproperty
  a_soft: assert property (p_soft)
    else $error("gentle halt did not ramp");

  property p_hard;
    moving && hit && !soft_r |=> (state_r == ST_WAIT) && (vel_o == '0);
  endproperty
  a_hard: assert property (p_hard)
    else $error("limit switch did not stop motion");

  property p_v1_off;
    (state_r == ST_RUN) && !v1_on |-> rate == amax_i;
  endproperty
  a_v1_off: assert property (p_v1_off)
    else $error("zero first-phase speed not skipped");

  property p_dmax;
    (state_r == ST_BRAKE) && v1_on && (v_r > VEL_W'(v1_r))
      |-> rate == dmax_r;
  endproperty
  a_dmax: assert property (p_dmax)
    else $error("max decel not used above first phase");

  property p_d1;
    (state_r == ST_BRAKE) && v1_on && (v_r <= VEL_W'(v1_r))
      |-> rate == d1_r;
  endproperty
  a_d1: assert property (p_d1)
    else $error("first-phase decel not used");

  property p_pause;
    (state_r == ST_WAIT)
      && (wait_cyc_r < (CYC_W'(pause_r) * CYC_W'(UNIT_CYC)))
      |=> state_r == ST_WAIT;
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause cut short");

  property p_modes;
    (meas_r > thr_r) && fchop_r && ffull_r
      |=> mode_o.chop_alt && mode_o.fullstep && mode_o.lac_off;
  endproperty
  a_modes: assert property (p_modes)
    else $error("high speed modes not selected");

  property p_adapt;
    !(meas_r > admin_r) |=> !mode_o.adapt;
  endproperty
  a_adapt: assert property (p_adapt)
    else $error("adaptive commutation below minimum");

  property p_meas;
    ap_rd_i && (ap_num_i == AP_MEAS) |=> ap_rdata_o == DW'($past(meas_r));
  endproperty
  a_meas: assert property (p_meas)
    else $error("measured speed read-back wrong");

  property p_reached;
    (target_pos_i == actual_pos_i) ##1 ap_rd_i && (ap_num_i == AP_REACHED)
      |=> ap_rdata_o == DW'(1);
  endproperty
  a_reached: assert property (p_reached)
    else $error("reached flag not set");

  c_move:  cover property ((state_r == ST_RUN) ##[1:1000]
                           (state_r == ST_WAIT));
  c_soft:  cover property ((state_r == ST_RUN) && hit && soft_r);
  c_phase: cover property ((state_r == ST_BRAKE) && v1_on
                           && (rate == d1_r));

endmodule : stm_axis_ctrl

// >>> testbench/stm_motor_model.sv
`timescale 1ns/100ps
module stm_motor_model
  import stm_pkg::*;
(
  input  wire logic             clk_i,  // module clock
  input  wire logic             nrst_i, // reset, low
  input  wire logic [POS_W-1:0] tgt_i,  // target position
  input  wire logic [VEL_W-1:0] vel_i,  // commanded speed
  input  wire logic             run_i,  // ramp active
  input  wire logic [VEL_W-1:0] extra_i, // added speed reading
  output logic      [POS_W-1:0] pos_o,  // shaft position
  output logic      [VEL_W-1:0] meas_o  // measured speed
);
  // ==========================================================
  // shaft: one step a cycle, clamped so late stops cannot oscillate
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos_o <= '0;
    end else if (run_i && vel_i != '0 && pos_o != tgt_i) begin
      pos_o <= ($signed(tgt_i) > $signed(pos_o)) ? pos_o + 1 : pos_o - 1;
    end
  end
  assign meas_o = vel_i + extra_i;
endmodule : stm_motor_model

// >>> testbench/stm_axis_ctrl_tb.sv
`timescale 1ns/100ps
module stm_axis_ctrl_tb
  import stm_pkg::*;
;
  logic             clk = 0, nrst = 0, wr = 0, rd = 0, ack, err;
  logic [AP_W-1:0]  num = '0;
  logic [DW-1:0]    wd = '0, rdat;
  logic [POS_W-1:0] tgt = '0, pos;
  logic [VEL_W-1:0] vel, meas, xs = '0;
  logic [CUR_W-1:0] cur;
  logic             dir, run, sr, sl;
  stm_mode_t        mode;
  stm_sw_t          sw = '0;
  int               error_cnt = 0, total_checks = 0;
  always #50 clk = ~clk;
  stm_axis_ctrl #(.TICK_CYC(4), .UNIT_CYC(2)) i_dut (
    .ref_clk_i(clk), .nrst_i(nrst), .ap_num_i(num), .ap_wdata_i(wd),
    .ap_wr_i(wr), .ap_rd_i(rd), .ap_rdata_o(rdat), .ap_ack_o(ack),
    .ap_err_o(err), .target_pos_i(tgt), .actual_pos_i(pos),
    .vmax_i(23'h20), .amax_i(23'h400), .run_cur_i(8'h80),
    .meas_speed_i(meas), .sw_i(sw), .vel_o(vel), .dir_o(dir),
    .running_o(run), .cur_o(cur), .mode_o(mode),
    .stop_right_o(sr), .stop_left_o(sl));
  stm_motor_model i_motor (.clk_i(clk), .nrst_i(nrst), .tgt_i(tgt),
    .vel_i(vel), .run_i(run), .extra_i(xs), .pos_o(pos), .meas_o(meas));
  // ==========================================================
  // access tasks
  task check(string nm, logic [DW-1:0] exp, logic [DW-1:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task acc(logic w, logic [AP_W-1:0] n, logic [DW-1:0] v, logic e);
    @(posedge clk); #1;
    wr = w; rd = !w; num = n; wd = v;
    @(posedge clk); #1;
    wr = 0; rd = 0;
    check("ack", 1'h1, ack);
    check("err", e, err);
  endtask : acc
  task get(logic [AP_W-1:0] n, logic [DW-1:0] exp);
    acc(0, n, '0, 0);
    check("rdata", exp, rdat);
  endtask : get
  task settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task wait_run(logic v, int n);
    for (int i = 0; i < n && run !== v; i++) settle(1);
    check("running", v, run);
  endtask : wait_run
  task print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #(100 * 40000);
    error_cnt++;
    print_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    settle(10);
    nrst = 1;
    settle(2);
    check("run_rst", 1'h0, run);
    get(AP_STANDBY, '0);
    acc(1, AP_STANDBY, 32'h1ff, 0);
    get(AP_STANDBY, 32'hff);
    check("cur_idle", 8'hff, cur);
    acc(1, AP_REACHED, 32'h1, 1);
    acc(0, 8'h20, '0, 1);
    check("rdata_bad", '0, rdat);
    get(AP_REACHED, 32'h1);
    sw.right = 1;
    settle(3);
    get(AP_RIGHT, 32'h1);
    check("stop_r", 1'h1, sr);
    acc(1, AP_R_IGN, 32'h1, 0);
    settle(1);
    check("stop_r_ign", 1'h0, sr);
    acc(1, AP_R_IGN, '0, 0);
    acc(1, AP_R_INV, 32'h1, 0);
    get(AP_RIGHT, '0);
    check("stop_r_inv", 1'h0, sr);
    acc(1, AP_R_INV, '0, 0);
    acc(1, AP_XCHG, 32'h1, 0);
    get(AP_LEFT, 32'h1);
    get(AP_RIGHT, '0);
    check("stop_l", 1'h1, sl);
    acc(1, AP_L_IGN, 32'h1, 0);
    settle(3);
    check("stop_l_ign", 1'h0, sl);
    get(AP_LEFT, 32'h1);
    sw = '0;
    acc(1, AP_XCHG, '0, 0);
    acc(1, AP_L_IGN, '0, 0);
    acc(1, AP_THR, 32'd100, 0);
    acc(1, AP_ADMIN, 32'd50, 0);
    acc(1, AP_FCHOP, 32'h1, 0);
    acc(1, AP_FFULL, 32'h1, 0);
    xs = 23'd200;
    settle(3);
    check("mode_hi", 4'hf, mode);
    get(AP_MEAS, 32'd200);
    xs = 23'd75;
    settle(3);
    check("mode_mid", 4'h1, mode);
    xs = '0;
    acc(1, AP_HALT, 32'h2, 0);
    acc(1, AP_LAUNCH, 32'h1, 0);
    acc(1, AP_PAUSE, 32'h3, 0);
    tgt = 32'd40;
    wait_run(1, 20);
    check("cur_run", 8'h80, cur);
    wait_run(0, 3000);
    check("pos", 32'd40, pos);
    tgt = '0;
    // pause is 3 units of 2 cycles, so 5 quiet cycles are owed
    repeat (5) begin
      settle(1);
      check("hold", 1'h0, run);
    end
    wait_run(1, 20);
    check("dir", 1'h0, dir);
    wait_run(0, 3000);
    get(AP_REACHED, 32'h1);
    check("cur_stop", 8'hff, cur);
    acc(1, AP_V1, 32'h3, 0);
    acc(1, AP_SOFT, 32'h1, 0);
    tgt = 32'd40;
    wait_run(1, 20);
    settle(12);
    sw.right = 1;
    settle(3);
    check("soft_run", 1'h1, run);
    wait_run(0, 200);
    check("soft_pos", 1'h1, pos < 32'd40);
    settle(20);
    check("blocked", 1'h0, run);
    acc(1, AP_SOFT, '0, 0);
    sw.right = 0;
    wait_run(1, 20);
    sw.right = 1;
    settle(3);
    check("hard_run", 1'h0, run);
    check("hard_vel", '0, vel);
    sw = '0;
    wait_run(1, 40);
    wait_run(0, 3000);
    check("pos_end", 32'd40, pos);
    print_verdict();
  end
endmodule : stm_axis_ctrl_tb
